//--- verilog/smc_cfg.svh
// Constants of the standby mode controller: offsets, fields, reset values
//
// Contract
// - Stop instruction enters STOP, halt enters HALT
// - Standby freezes core, keeps registers and memory
// - Refuse entry while any request flag set
// - STOP halts oscillator and divide-by-two stage
// - Only reset input leaves STOP
// - External clock source turns STOP into HALT
// - HALT gates system clock, oscillator keeps running
// - Timer count pulses continue during HALT
// - Serial keeps shifting on non-system clock sources
// - HALT ends on reset or any request flag
// - Enabled wake: one instruction, vector, clear flag
// - Source disabled: resume, no vector, flag kept
// - Master disabled: resume, no vector, flag kept
// - Interrupt wake resumes with registers unchanged
// - Reset in STOP: rise to HALT, fall resets
// - Reset in HALT: falling edge releases and resets
// - Reset high holds halt flip-flop set
// - Timer match sets the timer request flag
`ifndef SMC_CFG_SVH
`define SMC_CFG_SVH

// ==========================================================
// Register map
`define SMC_CTRL_OFS 32'h0000_0000
`define SMC_STAT_OFS 32'h0000_0004
`define SMC_FLAG_OFS 32'h0000_0008
`define SMC_ADDR_LSB 2
`define SMC_ADDR_MSB 7

// ==========================================================
// Control fields
`define SMC_CTRL_EXT_CLK_BIT 0
`define SMC_CTRL_SER_PHI_BIT 1
`define SMC_CTRL_RST 32'h0000_0002

// ==========================================================
// Status fields
`define SMC_STAT_STATE_LSB 0
`define SMC_STAT_REFUSED_BIT 2
`define SMC_STAT_RSTPIN_BIT 3
`define SMC_STAT_FLAGS_LSB 4

// ==========================================================
// Request sources: flag bit positions, bit 0 has highest priority
`define SMC_NUM_SRC 3
`define SMC_SRC_TIMER 0
`define SMC_SRC_SERIAL 1
`define SMC_SRC_PIN 2

`endif

//--- verilog/smc_pkg.sv
// Types of the standby mode controller
package smc_pkg;

	// ==========================================================
	// Standby state
	typedef enum logic [1:0] {
		SMC_RUN = 2'b00,
		SMC_HALT = 2'b01,
		SMC_STOP = 2'b10
	} smc_state_e;

	// ==========================================================
	// Core to controller
	typedef struct packed {
		logic halt_instr;
		logic stop_instr;
		logic master_enable;
		logic [2:0] source_enable;
		logic [2:0] flag_clear;
	} smc_core_req_s;

	// ==========================================================
	// Controller to core
	typedef struct packed {
		logic core_reset;
		logic wake_resume;
		logic wake_vector;
		logic [1:0] vector_source;
		logic entry_refused;
		logic [2:0] request_flags;
	} smc_core_ans_s;

	// ==========================================================
	// Clock gating controls
	typedef struct packed {
		logic osc_enable;
		logic sys_clk_enable;
		logic timer_count_enable;
		logic serial_clk_enable;
	} smc_clk_ctl_s;

endpackage

//--- verilog/smc_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module smc_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_ff;

	// ==========================================================
	// Synchroniser chain
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			meta_ff <= '0;
			sync_out <= '0;
		end else if (ce_in) begin
			meta_ff <= async_in;
			sync_out <= meta_ff;
		end
	end
endmodule // smc_sync

//--- verilog/smc_standby_ctrl.sv
// Standby mode controller: HALT/STOP sequencing, wake-up and AHB registers
`timescale 1ns/10ps
`include "smc_cfg.svh"
module smc_standby_ctrl (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	// Reset pin of the device, active high, asynchronous
	input wire logic reset_pin_in,
	// Request sources from timer, serial and pin logic
	input wire logic timer_match_request_in,
	input wire logic serial_byte_done_request_in,
	input wire logic external_pin_request_in,
	input wire smc_pkg::smc_core_req_s core_req_in,
	output smc_pkg::smc_core_ans_s core_ans_out,
	output smc_pkg::smc_clk_ctl_s clk_ctl_out,
	output smc_pkg::smc_state_e state_out,
	// AHB-Lite slave
	input wire logic hsel_in,
	input wire logic [31:0] haddr_in,
	input wire logic [1:0] htrans_in,
	input wire logic hwrite_in,
	input wire logic [2:0] hsize_in,
	input wire logic [31:0] hwdata_in,
	input wire logic hready_in,
	output logic [31:0] hrdata_out,
	output logic hreadyout_out,
	output logic hresp_out
);
	import smc_pkg::*;

	logic rst_lvl;
	logic rst_lvl_d_ff;
	logic rst_fall;
	logic [2:0] flags_ff;
	logic [2:0] nxt_flags;
	logic [2:0] flag_set;
	logic [2:0] vec_hit;
	logic any_flag;
	logic entry_req;
	smc_state_e state_ff;
	smc_state_e nxt_state;
	logic nxt_reset;
	logic nxt_resume;
	logic nxt_vector;
	logic nxt_refused;
	logic [1:0] nxt_src;
	logic [31:0] ctrl_ff;
	logic refused_ff;
	logic ext_clk;
	logic ser_phi;
	logic dp_wr_ff;
	logic [`SMC_ADDR_MSB:`SMC_ADDR_LSB] dp_addr_ff;
	logic ap_valid;
	logic [31:0] rd_data;
	// Offsets held as typed constants so that their word index can be sliced
	localparam logic [31:0] ctrl_ofs = `SMC_CTRL_OFS;
	localparam logic [31:0] stat_ofs = `SMC_STAT_OFS;
	localparam logic [31:0] flag_ofs = `SMC_FLAG_OFS;

	// ==========================================================
	// Reset pin synchronisation and edge detection
	smc_sync #(
		.WIDTH(1)
	) u_rst_sync (
		.clk_in(clk_in),
		.rstn_in(rstn_in),
		.ce_in(ce_in),
		.async_in(reset_pin_in),
		.sync_out(rst_lvl)
	);

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			rst_lvl_d_ff <= 1'b0;
		end else if (ce_in) begin
			rst_lvl_d_ff <= rst_lvl;
		end
	end

	assign rst_fall = rst_lvl_d_ff & ~rst_lvl;
	assign ext_clk = ctrl_ff[`SMC_CTRL_EXT_CLK_BIT];
	assign ser_phi = ctrl_ff[`SMC_CTRL_SER_PHI_BIT];

	// ==========================================================
	// Request flags
	// Sources are frozen in STOP, so sets are ignored there.
	always_comb begin
		flag_set = '0;
		flag_set[`SMC_SRC_TIMER] = timer_match_request_in;
		flag_set[`SMC_SRC_SERIAL] = serial_byte_done_request_in;
		flag_set[`SMC_SRC_PIN] = external_pin_request_in;
		if (state_ff == SMC_STOP) begin
			flag_set = '0;
		end
		// Set wins over a clear in the same cycle
		nxt_flags = (flags_ff & ~core_req_in.flag_clear) | flag_set;
		if (rst_lvl) begin
			nxt_flags = '0;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			flags_ff <= '0;
		end else if (ce_in) begin
			flags_ff <= nxt_flags;
		end
	end

	assign any_flag = |flags_ff;
	assign entry_req = core_req_in.halt_instr | core_req_in.stop_instr;
	assign vec_hit = flags_ff & core_req_in.source_enable
		& {3{core_req_in.master_enable}};

	// ==========================================================
	// Standby state machine
	always_comb begin
		nxt_state = state_ff;
		nxt_reset = 1'b0;
		nxt_resume = 1'b0;
		nxt_vector = 1'b0;
		nxt_refused = 1'b0;
		nxt_src = 2'h0;
		case (state_ff)
			SMC_RUN: begin
				if (rst_lvl) begin
					nxt_state = SMC_HALT;
				end else if (entry_req && any_flag) begin
					nxt_refused = 1'b1;
				end else if (core_req_in.stop_instr && !ext_clk) begin
					nxt_state = SMC_STOP;
				end else if (entry_req) begin
					nxt_state = SMC_HALT;
				end
			end
			SMC_HALT: begin
				if (rst_fall) begin
					nxt_state = SMC_RUN;
					nxt_reset = 1'b1;
				end else if (rst_lvl) begin
					nxt_state = SMC_HALT;
				end else if (any_flag) begin
					nxt_state = SMC_RUN;
					nxt_resume = 1'b1;
					if (|vec_hit) begin
						nxt_vector = 1'b1;
						if (vec_hit[`SMC_SRC_TIMER]) begin
							nxt_src = 2'(`SMC_SRC_TIMER);
						end else if (vec_hit[`SMC_SRC_SERIAL]) begin
							nxt_src = 2'(`SMC_SRC_SERIAL);
						end else begin
							nxt_src = 2'(`SMC_SRC_PIN);
						end
					end
					// Without a hit the flag stays for software to poll
				end
			end
			SMC_STOP: begin
				// Interrupts cannot wake STOP; the oscillator is down
				if (rst_lvl) begin
					nxt_state = SMC_HALT;
				end
			end
			default: begin
				nxt_state = SMC_RUN;
			end
		endcase
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			state_ff <= SMC_RUN;
		end else if (ce_in) begin
			state_ff <= nxt_state;
		end
	end

	assign state_out = state_ff;

	// ==========================================================
	// Core answers, registered pulses
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			core_ans_out <= '0;
		end else if (ce_in) begin
			core_ans_out.core_reset <= nxt_reset;
			core_ans_out.wake_resume <= nxt_resume;
			core_ans_out.wake_vector <= nxt_vector;
			core_ans_out.vector_source <= nxt_src;
			core_ans_out.entry_refused <= nxt_refused;
			core_ans_out.request_flags <= nxt_flags;
		end
	end

	// ==========================================================
	// Clock gating, taken from the next state so gates follow at once
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			clk_ctl_out <= '0;
		end else if (ce_in) begin
			clk_ctl_out.osc_enable <= (nxt_state != SMC_STOP);
			clk_ctl_out.sys_clk_enable <= (nxt_state == SMC_RUN);
			clk_ctl_out.timer_count_enable <= (nxt_state != SMC_STOP);
			clk_ctl_out.serial_clk_enable <= (nxt_state == SMC_RUN)
				|| (nxt_state == SMC_HALT && !ser_phi);
		end
	end

	// ==========================================================
	// AHB-Lite slave, zero wait states, always OKAY
	assign ap_valid = hsel_in & hready_in & htrans_in[1];

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			dp_wr_ff <= 1'b0;
			dp_addr_ff <= '0;
		end else if (ce_in) begin
			dp_wr_ff <= ap_valid & hwrite_in;
			dp_addr_ff <= haddr_in[`SMC_ADDR_MSB:`SMC_ADDR_LSB];
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end else if (ce_in) begin
			hreadyout_out <= 1'b1;
			hresp_out <= 1'b0;
		end
	end

	// Control register; hsize is not checked, every write is a word
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			ctrl_ff <= `SMC_CTRL_RST;
		end else if (ce_in) begin
			if (dp_wr_ff && dp_addr_ff ==
				ctrl_ofs[`SMC_ADDR_MSB:`SMC_ADDR_LSB]) begin
				ctrl_ff <= {30'h0, hwdata_in[1:0]};
			end
		end
	end

	// Sticky refusal, write one to clear; a new refusal wins
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			refused_ff <= 1'b0;
		end else if (ce_in) begin
			if (nxt_refused) begin
				refused_ff <= 1'b1;
			end else if (dp_wr_ff && dp_addr_ff ==
				stat_ofs[`SMC_ADDR_MSB:`SMC_ADDR_LSB] &&
				hwdata_in[`SMC_STAT_REFUSED_BIT]) begin
				refused_ff <= 1'b0;
			end
		end
	end

	// Read data is sampled in the address phase and stands in the data
	// phase, so a read never sees a same-cycle write to its register.
	always_comb begin
		rd_data = 32'h0;
		if (haddr_in[`SMC_ADDR_MSB:`SMC_ADDR_LSB] ==
			ctrl_ofs[`SMC_ADDR_MSB:`SMC_ADDR_LSB]) begin
			rd_data = ctrl_ff;
		end else if (haddr_in[`SMC_ADDR_MSB:`SMC_ADDR_LSB] ==
			stat_ofs[`SMC_ADDR_MSB:`SMC_ADDR_LSB]) begin
			rd_data[`SMC_STAT_STATE_LSB +: 2] = state_ff;
			rd_data[`SMC_STAT_REFUSED_BIT] = refused_ff;
			rd_data[`SMC_STAT_RSTPIN_BIT] = rst_lvl;
			rd_data[`SMC_STAT_FLAGS_LSB +: 3] = flags_ff;
		end else if (haddr_in[`SMC_ADDR_MSB:`SMC_ADDR_LSB] ==
			flag_ofs[`SMC_ADDR_MSB:`SMC_ADDR_LSB]) begin
			rd_data[2:0] = flags_ff;
		end
	end

	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			hrdata_out <= 32'h0;
		end else if (ce_in) begin
			if (ap_valid && !hwrite_in) begin
				hrdata_out <= rd_data;
			end
		end
	end
endmodule // smc_standby_ctrl

//--- tb/smc_properties.sv
// Port assertions of the standby controller
`timescale 1ns/10ps
module smc_properties (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire logic ce_in,
	input wire logic reset_pin_in,
	input wire logic timer_match_request_in,
	input wire logic serial_byte_done_request_in,
	input wire logic external_pin_request_in,
	input wire smc_pkg::smc_core_req_s core_req_in,
	input wire smc_pkg::smc_core_ans_s core_ans_out,
	input wire smc_pkg::smc_clk_ctl_s clk_ctl_out,
	input wire smc_pkg::smc_state_e state_out
);
	import smc_pkg::*;
	logic [2:0] src;
	logic [2:0] en_ff;
	assign src = {external_pin_request_in, serial_byte_done_request_in,
		timer_match_request_in};
	// Enables as seen at the wake edge
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			en_ff <= 3'h0;
		end else begin
			en_ff <= core_req_in.source_enable & {3{core_req_in.master_enable}};
		end
	end
	default clocking @(posedge clk_in); endclocking
	// A frozen block keeps its state, so nothing is due while enable is low
	default disable iff (!rstn_in || !ce_in);
	// ====
	// Standby
	a_halt_entry: assert property (core_req_in.halt_instr &&
		state_out == SMC_RUN && core_ans_out.request_flags == 3'h0 &&
		src == 3'h0 && $past(src) == 3'h0 && !reset_pin_in
		|=> state_out == SMC_HALT) else $error("no halt");
	a_entry_refused: assert property (core_req_in.stop_instr &&
		state_out == SMC_RUN && core_ans_out.request_flags != 3'h0 &&
		$past(core_req_in.flag_clear) == 3'h0 && !reset_pin_in
		|=> core_ans_out.entry_refused && state_out == SMC_RUN)
		else $error("not refused");
	a_stop_clocks: assert property (state_out == SMC_STOP
		|-> clk_ctl_out == 4'h0) else $error("clocks in stop");
	a_halt_clocks: assert property (state_out == SMC_HALT |->
		clk_ctl_out.osc_enable && clk_ctl_out.timer_count_enable &&
		!clk_ctl_out.sys_clk_enable) else $error("clocks in halt");
	a_stop_hold: assert property (state_out == SMC_STOP &&
		!reset_pin_in && !$past(reset_pin_in) |=> state_out == SMC_STOP)
		else $error("stop left");
	a_stop_to_halt: assert property (state_out == SMC_STOP &&
		$rose(reset_pin_in) |-> ##[2:3] state_out == SMC_HALT)
		else $error("no halt on rise");
	a_pin_release: assert property (state_out == SMC_HALT &&
		$fell(reset_pin_in) |-> ##[2:4] core_ans_out.core_reset &&
		state_out == SMC_RUN) else $error("no release");
	a_pin_holds: assert property (reset_pin_in [*3] |=>
		state_out == SMC_HALT && !clk_ctl_out.sys_clk_enable)
		else $error("halt not held");
	a_halt_wake: assert property (state_out == SMC_HALT &&
		src != 3'h0 && !reset_pin_in |-> ##[1:3]
		core_ans_out.wake_resume && state_out == SMC_RUN)
		else $error("no wake");
	a_vector_gate: assert property (
		core_ans_out.wake_vector |-> core_ans_out.wake_resume &&
		en_ff[core_ans_out.vector_source]) else $error("bad vector");
endmodule // smc_properties

bind smc_standby_ctrl smc_properties smc_properties_i (.*);

//--- tb/smc_core_model.sv
// Core model: clears the vectored request one instruction later
`timescale 1ns/10ps
module smc_core_model (
	input wire logic clk_in,
	input wire logic rstn_in,
	input wire smc_pkg::smc_core_ans_s core_ans_in,
	output logic [2:0] flag_clear_out
);
	import smc_pkg::*;
	logic pend_ff;
	logic [1:0] src_ff;
	always_ff @(posedge clk_in or negedge rstn_in) begin
		if (!rstn_in) begin
			pend_ff <= 1'h0;
			src_ff <= 2'h0;
			flag_clear_out <= 3'h0;
		end else begin
			pend_ff <= core_ans_in.wake_vector;
			src_ff <= core_ans_in.vector_source;
			flag_clear_out <= pend_ff ? 3'h1 << src_ff : 3'h0;
		end
	end
endmodule // smc_core_model

//--- tb/tb_top.sv
// Bench of the standby mode controller
`timescale 1ns/10ps
`include "smc_cfg.svh"
module tb_top;
	import smc_pkg::*;
	logic clk_in;
	logic rstn_in;
	logic ce;
	logic pin;
	logic [2:0] src;
	logic [2:0] mclr;
	smc_core_req_s req;
	smc_core_req_s creq;
	smc_core_ans_s ans;
	smc_clk_ctl_s ck;
	smc_state_e st;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	logic [31:0] hrdata;
	logic hready;
	logic [31:0] rd;
	int num_errors;
	int check_count;
	// ====
	// Design and core model
	always_comb begin
		creq = req;
		creq.flag_clear = req.flag_clear | mclr;
	end
	smc_standby_ctrl smc_standby_ctrl_i (.clk_in(clk_in), .rstn_in(rstn_in),
		.ce_in(ce), .reset_pin_in(pin), .timer_match_request_in(src[0]),
		.serial_byte_done_request_in(src[1]),
		.external_pin_request_in(src[2]), .core_req_in(creq),
		.core_ans_out(ans), .clk_ctl_out(ck), .state_out(st), .hsel_in(1'h1),
		.haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
		.hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready),
		.hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out());
	smc_core_model smc_core_model_i (.clk_in(clk_in), .rstn_in(rstn_in),
		.core_ans_in(ans), .flag_clear_out(mclr));
	// ====
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic ahb(input logic wr, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge clk_in);
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= wr;
		do @(posedge clk_in); while (hready !== 1'h1);
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clk_in); while (hready !== 1'h1);
		rd = hrdata;
	endtask
	task automatic instr(input logic stp);
		@(posedge clk_in);
		req.halt_instr <= !stp;
		req.stop_instr <= stp;
		@(posedge clk_in);
		req.halt_instr <= 1'h0;
		req.stop_instr <= 1'h0;
		#1;
	endtask
	task automatic fire(input logic [2:0] s);
		@(posedge clk_in);
		src <= s;
		@(posedge clk_in);
		src <= 3'h0;
	endtask
	task automatic clear;
		@(posedge clk_in);
		req.flag_clear <= 3'h7;
		@(posedge clk_in);
		req.flag_clear <= 3'h0;
	endtask
	// Bit 8 is core_reset, bit 7 wake_resume of the answer
	task automatic await(input int b);
		for (int k = 0; k < 20; k++) begin
			@(posedge clk_in);
			#1;
			if (ans[b] === 1'h1) break;
		end
	endtask
	task automatic pin_cycle;
		@(posedge clk_in);
		pin <= 1'h1;
		repeat (6) @(posedge clk_in);
		#1;
		check(st, SMC_HALT);
		check(ck, 4'hb);
		@(posedge clk_in);
		pin <= 1'h0;
		await(8);
		check(ans.core_reset, 1'h1);
		check(st, SMC_RUN);
	endtask
	// ====
	// Scenarios
	task automatic t_regs;
		ahb(1'h0, `SMC_CTRL_OFS, 32'h0);
		check(rd, `SMC_CTRL_RST);
		ahb(1'h1, 32'h40, 32'hffff_ffff);
		ahb(1'h0, 32'h40, 32'h0);
		check(rd, 32'h0);
		ahb(1'h1, `SMC_CTRL_OFS, 32'h0);
		ahb(1'h0, `SMC_STAT_OFS, 32'h0);
		check(rd, 32'h0);
	endtask
	task automatic t_wake;
		for (int c = 0; c < 4; c++) begin
			@(posedge clk_in);
			req.master_enable <= c != 3;
			req.source_enable <= c == 2 ? 3'h0 : 3'h7;
			instr(1'h0);
			check(st, SMC_HALT);
			check(ck, 4'hb);
			fire(3'h1 << (c % 3));
			await(7);
			check(ans.wake_resume, 1'h1);
			check(ans.wake_vector, c < 2);
			check(st, SMC_RUN);
			check(ck, 4'hf);
			if (c < 2) check(ans.vector_source, c);
			repeat (5) @(posedge clk_in);
			#1;
			check(ans.request_flags, c < 2 ? 3'h0 : 3'h1 << (c % 3));
			clear;
		end
	endtask
	task automatic t_refuse;
		fire(3'h4);
		repeat (2) @(posedge clk_in);
		instr(1'h1);
		check(ans.entry_refused, 1'h1);
		check(st, SMC_RUN);
		clear;
	endtask
	task automatic t_ce;
		@(posedge clk_in);
		ce <= 1'h0;
		fire(3'h1);
		instr(1'h0);
		check(st, SMC_RUN);
		check(ans.request_flags, 3'h0);
		@(posedge clk_in);
		ce <= 1'h1;
		repeat (2) @(posedge clk_in);
		#1;
		check(st, SMC_RUN);
		check(ans.request_flags, 3'h0);
	endtask
	task automatic t_stop;
		instr(1'h1);
		check(st, SMC_STOP);
		check(ck, 4'h0);
		fire(3'h7);
		repeat (4) @(posedge clk_in);
		#1;
		check(st, SMC_STOP);
		pin_cycle;
		ahb(1'h1, `SMC_CTRL_OFS, 32'h1);
		instr(1'h1);
		check(st, SMC_HALT);
		pin_cycle;
	endtask
	task automatic complete_run;
		if (num_errors == 0 && check_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// ====
	// Clock, reset and sequence
	initial begin
		clk_in = 1'h0;
		forever #10 clk_in = ~clk_in;
	end
	initial begin
		rstn_in = 1'h0;
		ce = 1'h1;
		pin = 1'h0;
		src = 3'h0;
		req = '0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'h0;
		hwdata = 32'h0;
		num_errors = 0;
		check_count = 0;
		repeat (16) @(posedge clk_in);
		rstn_in <= 1'h1;
		t_regs;
		t_wake;
		t_refuse;
		t_ce;
		t_stop;
		complete_run;
	end
	// Whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_in);
		num_errors++;
		complete_run;
	end
endmodule // tb_top
